// ### timer16_waveform_modes.v
/*
 Waveform timer: normal, clear-on-compare and fast PWM, AXI4-Lite slave.
 Assumes aclk, a synchronous active-low reset, a same-clock bus master.
*/
`timescale 1ns/10ps
`default_nettype none
`include "timer16_consts.vh"

module timer16_waveform_modes (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         waveform_output_a_pin,
	output reg         waveform_output_a_oe,
	output reg         waveform_output_b_pin,
	output reg         waveform_output_b_oe
);

// ********************************************************
// Functions
// ********************************************************
function [31:0] merge;
	input [31:0] old;
	input [31:0] nw;
	input [3:0]  be;
	integer i;
	begin
		merge = old;
		for (i = 0; i < 4; i = i + 1) begin
			if (be[i])
				merge[i*8 +: 8] = nw[i*8 +: 8];
		end
	end
endfunction

function is_pwm;
	input [3:0] m;
	begin
		is_pwm = (m == `MD_FAST8) || (m == `MD_FAST9) ||
			(m == `MD_FAST10) || (m == `MD_FAST_C) ||
			(m == `MD_FAST_A);
	end
endfunction

// Fixed-TOP modes mask compare writes; other modes pass all bits
function [15:0] top_mask;
	input [3:0] m;
	begin
		if (m == `MD_FAST8)
			top_mask = `TOP_8;
		else if (m == `MD_FAST9)
			top_mask = `TOP_9;
		else if (m == `MD_FAST10)
			top_mask = `TOP_10;
		else
			top_mask = `CNT_MAX;
	end
endfunction

// Next level of a waveform output
function next_wave;
	input       cur;
	input [1:0] com;
	input       pwm;
	input       tog_ok;
	input       match;
	input       top;
	begin
		next_wave = cur;
		if (pwm) begin
			if (com == `COM_TOGGLE) begin
				if (tog_ok && match)
					next_wave = ~cur;
			end else if (com != `COM_NONE) begin
				// TOP wins over a match in one tick
				if (top)
					next_wave = (com == `COM_CLEAR);
				else if (match)
					next_wave = (com == `COM_SET);
			end
		end else if (match) begin
			if (com == `COM_TOGGLE)
				next_wave = ~cur;
			else if (com != `COM_NONE)
				next_wave = (com == `COM_SET);
		end
	end
endfunction

// ********************************************************
// State
// ********************************************************
reg  [12:0] ctrl_q;
reg  [15:0] count_q;
reg  [15:0] cmpa_q;
reg  [15:0] cmpa_buf_q;
reg  [15:0] cmpb_q;
reg  [15:0] cmpb_buf_q;
reg  [15:0] capt_q;
reg  [3:0]  flags_q;
reg         block_q;
reg  [9:0]  pre_q;
reg         wave_a_q;
reg         wave_b_q;

wire [3:0]  mode  = ctrl_q[`CTL_MODE_LO +: 4];
wire [1:0]  com_a = ctrl_q[`CTL_COMA_LO +: 2];
wire [1:0]  com_b = ctrl_q[`CTL_COMB_LO +: 2];
wire [2:0]  cs    = ctrl_q[`CTL_CS_LO +: 3];
wire        pwm   = is_pwm(mode);
wire        clear_on_compare_mode   = (mode == `MD_CTC_A) || (mode == `MD_CTC_C);
wire        norm  = (mode == `MD_NORMAL);
wire        known = pwm || clear_on_compare_mode || norm;

// ********************************************************
// Prescaler
// ********************************************************
reg tick;

always @* begin
	if (cs == `CS_DIV1)
		tick = 1'b1;
	else if (cs == `CS_DIV8)
		tick = ((pre_q & `PS_M8) == `PS_M8);
	else if (cs == `CS_DIV64)
		tick = ((pre_q & `PS_M64) == `PS_M64);
	else if (cs == `CS_DIV256)
		tick = ((pre_q & `PS_M256) == `PS_M256);
	else if (cs == `CS_DIV1024)
		tick = (pre_q == `PS_M1024);
	else
		tick = 1'b0;
end

always @(posedge aclk) begin
	if (!aresetn || cs == `CS_STOP)
		pre_q <= 10'h000;
	else
		pre_q <= pre_q + 10'h001;
end

// ********************************************************
// TOP selection and comparators
// ********************************************************
reg [15:0] top_val;

always @* begin
	if (mode == `MD_CTC_A || mode == `MD_FAST_A)
		top_val = cmpa_q;
	else if (mode == `MD_CTC_C || mode == `MD_FAST_C)
		top_val = capt_q;
	else if (mode == `MD_FAST8)
		top_val = `TOP_8;
	else if (mode == `MD_FAST9)
		top_val = `TOP_9;
	else if (mode == `MD_FAST10)
		top_val = `TOP_10;
	else
		top_val = `CNT_MAX;
end

// TOP regs are compared live, so a TOP below the count is missed
wire at_top  = (clear_on_compare_mode || pwm) && (count_q == top_val);
wire at_max  = (count_q == `CNT_MAX);
wire match_a = (count_q == cmpa_q) && !block_q;
wire match_b = (count_q == cmpb_q) && !block_q;
wire match_c = (count_q == capt_q) && !block_q;

// ********************************************************
// Bus decode
// ********************************************************
wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
	!s_axi_bvalid;
wire rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
wire [7:0]  wa = s_axi_awaddr;
wire [31:0] wd = s_axi_wdata;
wire [3:0]  be = s_axi_wstrb;

wire wr_ctrl  = wr_go && (wa == `OFS_CTRL);
wire wr_count = wr_go && (wa == `OFS_COUNT);
wire wr_cmpa  = wr_go && (wa == `OFS_CMPA);
wire wr_cmpb  = wr_go && (wa == `OFS_CMPB);
wire wr_capt  = wr_go && (wa == `OFS_CAPT);
wire wr_flags = wr_go && (wa == `OFS_FLAGS);

wire [31:0] merged_ctrl  = merge({19'h0, ctrl_q}, wd, be);
wire [31:0] merged_count = merge({16'h0, count_q}, wd, be);
wire [31:0] merged_capt  = merge({16'h0, capt_q}, wd, be);
wire [31:0] merged_cmpa  = merge({16'h0, cmpa_buf_q}, wd, be);
wire [31:0] merged_cmpb  = merge({16'h0, cmpb_buf_q}, wd, be);
wire [15:0] new_cmpa     = merged_cmpa[15:0] & top_mask(mode);
wire [15:0] new_cmpb     = merged_cmpb[15:0] & top_mask(mode);
wire [3:0]  clr_f        = (wr_flags && be[0]) ? wd[3:0] : 4'h0;

// ********************************************************
// Counter, compare values and flags
// ********************************************************
reg [3:0] set_f;

always @* begin
	set_f = 4'h0;
	if (tick && known) begin
		// Normal and clear-on-compare overflow on max to zero
		set_f[`FLG_OVF] = pwm ? at_top : at_max;
		set_f[`FLG_CMPA] = match_a;
		set_f[`FLG_CMPB] = match_b;
		if ((mode == `MD_CTC_C || mode == `MD_FAST_C) && match_c)
			set_f[`FLG_CAPT] = 1'b1;
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		ctrl_q     <= `CTRL_RST;
		count_q    <= `CNT_BOTTOM;
		cmpa_q     <= `CNT_BOTTOM;
		cmpa_buf_q <= `CNT_BOTTOM;
		cmpb_q     <= `CNT_BOTTOM;
		cmpb_buf_q <= `CNT_BOTTOM;
		capt_q     <= `CNT_BOTTOM;
		flags_q    <= 4'h0;
		block_q    <= 1'b0;
	end else begin
		if (wr_ctrl)
			ctrl_q <= merged_ctrl[12:0];
		// Software write wins over a timer step
		if (wr_count) begin
			count_q <= merged_count[15:0];
			block_q <= 1'b1;
		end else if (tick) begin
			block_q <= 1'b0;
			if (at_top)
				count_q <= `CNT_BOTTOM;
			else if (known)
				count_q <= count_q + 16'h0001;
		end
		if (wr_cmpa) begin
			cmpa_buf_q <= new_cmpa;
			if (!pwm)
				cmpa_q <= new_cmpa;
		end
		if (wr_cmpb) begin
			cmpb_buf_q <= new_cmpb;
			if (!pwm)
				cmpb_q <= new_cmpb;
		end
		if (pwm && tick && at_top) begin
			cmpa_q <= wr_cmpa ? new_cmpa : cmpa_buf_q;
			cmpb_q <= wr_cmpb ? new_cmpb : cmpb_buf_q;
		end
		if (wr_capt)
			capt_q <= merged_capt[15:0];
		// Set wins over a write-one clear in the same cycle
		flags_q <= (flags_q & ~clr_f) | set_f;
	end
end

// ********************************************************
// Waveform outputs and pins
// ********************************************************
always @(posedge aclk) begin
	if (!aresetn) begin
		wave_a_q              <= 1'b0;
		wave_b_q              <= 1'b0;
		waveform_output_a_pin <= 1'b0;
		waveform_output_a_oe  <= 1'b0;
		waveform_output_b_pin <= 1'b0;
		waveform_output_b_oe  <= 1'b0;
	end else begin
		if (tick && known) begin
			wave_a_q <= next_wave(wave_a_q, com_a, pwm,
				mode == `MD_FAST_A, match_a, at_top);
			wave_b_q <= next_wave(wave_b_q, com_b, pwm, 1'b0,
				match_b, at_top);
		end
		// Port data is not modelled: without an action the pin is low
		waveform_output_a_pin <= (com_a != `COM_NONE) & wave_a_q;
		waveform_output_b_pin <= (com_b != `COM_NONE) & wave_b_q;
		waveform_output_a_oe  <= ctrl_q[`CTL_DIRA];
		waveform_output_b_oe  <= ctrl_q[`CTL_DIRB];
	end
end

// ********************************************************
// AXI4-Lite write channel
// ********************************************************
wire wa_ok = wr_ctrl || wr_count || wr_cmpa || wr_cmpb || wr_capt ||
	wr_flags || (wa == `OFS_STATUS);

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_awready <= 1'b0;
		s_axi_wready  <= 1'b0;
		s_axi_bvalid  <= 1'b0;
		s_axi_bresp   <= `RESP_OKAY;
	end else begin
		s_axi_awready <= wr_go;
		s_axi_wready  <= wr_go;
		if (wr_go)
			s_axi_bresp <= wa_ok ? `RESP_OKAY : `RESP_SLVERR;
		if (s_axi_awready)
			s_axi_bvalid <= 1'b1;
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end
end

// ********************************************************
// AXI4-Lite read channel
// ********************************************************
reg [31:0] rd_d;
reg        rd_ok;

always @* begin
	rd_d  = 32'h00000000;
	rd_ok = 1'b1;
	if (s_axi_araddr == `OFS_CTRL)
		rd_d = {19'h0, ctrl_q};
	else if (s_axi_araddr == `OFS_COUNT)
		rd_d = {16'h0, count_q};
	else if (s_axi_araddr == `OFS_CMPA)
		rd_d = {16'h0, cmpa_buf_q};
	else if (s_axi_araddr == `OFS_CMPB)
		rd_d = {16'h0, cmpb_buf_q};
	else if (s_axi_araddr == `OFS_CAPT)
		rd_d = {16'h0, capt_q};
	else if (s_axi_araddr == `OFS_FLAGS)
		rd_d = {28'h0, flags_q};
	else if (s_axi_araddr == `OFS_STATUS)
		rd_d = {30'h0, wave_b_q, wave_a_q};
	else
		rd_ok = 1'b0;
end

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid  <= 1'b0;
		s_axi_rdata   <= 32'h00000000;
		s_axi_rresp   <= `RESP_OKAY;
	end else begin
		s_axi_arready <= rd_go;
		if (rd_go) begin
			s_axi_rdata <= rd_d;
			s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (s_axi_arready)
			s_axi_rvalid <= 1'b1;
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
end

endmodule
`default_nettype wire

// ### timer16_consts.vh
/*
 Constants of the 16-bit waveform timer: register offsets, field
 positions, reset values, mode codes and fixed TOP values.
 Assumes inclusion by the design file and its bench.
*/
`ifndef TIMER16_CONSTS_VH
`define TIMER16_CONSTS_VH

// Register byte offsets
`define OFS_CTRL    8'h00
`define OFS_COUNT   8'h04
`define OFS_CMPA    8'h08
`define OFS_CMPB    8'h0C
`define OFS_CAPT    8'h10
`define OFS_FLAGS   8'h14
`define OFS_STATUS  8'h18

// Control fields
`define CTL_MODE_LO 0
`define CTL_COMA_LO 4
`define CTL_COMB_LO 6
`define CTL_CS_LO   8
`define CTL_DIRA    11
`define CTL_DIRB    12
`define CTRL_RST    13'h0000

// Flag bits
`define FLG_OVF     0
`define FLG_CMPA    1
`define FLG_CMPB    2
`define FLG_CAPT    3

// Mode codes
`define MD_NORMAL   4'h0
`define MD_CTC_A    4'h4
`define MD_FAST8    4'h5
`define MD_FAST9    4'h6
`define MD_FAST10   4'h7
`define MD_CTC_C    4'hC
`define MD_FAST_C   4'hE
`define MD_FAST_A   4'hF

// Output actions
`define COM_NONE    2'h0
`define COM_TOGGLE  2'h1
`define COM_CLEAR   2'h2
`define COM_SET     2'h3

// Counter limits and fixed TOP values
`define CNT_MAX     16'hFFFF
`define CNT_BOTTOM  16'h0000
`define TOP_8       16'h00FF
`define TOP_9       16'h01FF
`define TOP_10      16'h03FF

// Prescaler: select codes and masks of the divider counter
`define CS_STOP     3'h0
`define CS_DIV1     3'h1
`define CS_DIV8     3'h2
`define CS_DIV64    3'h3
`define CS_DIV256   3'h4
`define CS_DIV1024  3'h5
`define PS_M8       10'h007
`define PS_M64      10'h03F
`define PS_M256     10'h0FF
`define PS_M1024    10'h3FF

`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// ### timer16_waveform_modes_chk.sv
/*
 Concurrent checks on the ports of timer16_waveform_modes: register bus
 handshakes and the pin enable of waveform A.
 Assumes one clock aclk, a synchronous active-low aresetn, and the bind
 statement at the foot of this file.
*/
`timescale 1ns/10ps
`default_nettype none
module timer16_waveform_modes_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        waveform_output_a_pin,
	input wire logic        waveform_output_a_oe,
	input wire logic        waveform_output_b_pin,
	input wire logic        waveform_output_b_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	aw_w_pair_a: assert property (s_axi_awready |-> s_axi_wready)
		else $error("write address and data ready differ");
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	aw_cause_a: assert property
		(s_axi_awready |-> $past(s_axi_awvalid && s_axi_wvalid))
		else $error("awready without both requests");
	b_follow_a: assert property (s_axi_awready |=> s_axi_bvalid)
		else $error("write response late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	r_follow_a: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	r_err_zero_a: assert property
		(s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("error read with data");
	oe_cause_a: assert property ($changed(waveform_output_a_oe) |->
		s_axi_awready || $past(s_axi_awready) || $past(s_axi_awready, 2))
		else $error("pin enable moved without a write");
endmodule
bind timer16_waveform_modes timer16_waveform_modes_chk i_chk (.*);
`default_nettype wire

// ### timer16_waveform_modes_bench.sv
/*
 Self-checking bench for timer16_waveform_modes: register traffic and
 waveform periods measured on pin A against a behavioural model.
 Assumes the constants header and a 100 MHz aclk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "timer16_consts.vh"
module timer16_waveform_modes_bench;
	logic        aclk = 0, aresetn = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, seed = 32'h524312CE, d;
	logic [3:0]  wstrb = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	wire logic   awready, wready, bvalid, arready, rvalid, pa, pao, pb, pbo;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	int          mismatches = 0, compares = 0, cyc = 0, t;

	timer16_waveform_modes i_timer16_waveform_modes (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .waveform_output_a_pin(pa),
		.waveform_output_a_oe(pao), .waveform_output_b_pin(pb),
		.waveform_output_b_oe(pbo));

	always #5 aclk = ~aclk;
	// Watchdog: a constant pin would otherwise hang a measurement
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			end_of_test();
		end
	end

	// ****************************************
	// Bus tasks and comparison
	// ****************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input string nm, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] er = 2'h0, input logic [3:0] s = 4'hF);
		logic h;
		logic [1:0] r;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin @(negedge aclk); h = awready; @(posedge aclk); end
		while (h !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		do begin @(negedge aclk); h = bvalid; r = bresp; @(posedge aclk); end
		while (h !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {30'h0, r}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		input logic [1:0] er = 2'h0);
		logic h;
		logic [1:0] r;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin @(negedge aclk); h = arready; @(posedge aclk); end
		while (h !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do begin @(negedge aclk); h = rvalid; r = rresp; v = rdata; @(posedge aclk); end
		while (h !== 1'b1);
		rready <= 1'b0;
		chk("rresp", {30'h0, r}, {30'h0, er});
	endtask

	// Cycles for which pin A keeps one level, sampled at falling edges
	task automatic hold(input logic l, output int n);
		n = 0;
		while (pa === l) begin
			n++;
			@(negedge aclk);
		end
	endtask

	// ****************************************
	// Model of one waveform case
	// ****************************************
	task automatic run_case(input int md, act, cs, capt, cmpa);
		int dv, tp, c, eh, el, hi, lo, k, pw;
		dv = cs == 1 ? 1 : cs == 2 ? 8 : cs == 3 ? 64 : cs == 4 ? 256 : 1024;
		tp = md == 5 ? 'hFF : md == 6 ? 'h1FF : md == 7 ? 'h3FF :
			(md == 12 || md == 14) ? capt : cmpa;
		c = (md >= 5 && md <= 7) ? (cmpa & tp) : cmpa;
		pw = (md >= 5 && md <= 7) || md >= 14;
		eh = act == 1 ? (tp + 1) * dv : act == 2 ? (c + 1) * dv : (tp - c) * dv;
		el = act == 1 ? eh : act == 2 ? (tp - c) * dv : (c + 1) * dv;
		wr(`OFS_CTRL, md);
		wr(`OFS_COUNT, 0);
		chk("oe_off", {31'h0, pao}, 0);
		chk("oe_b_off", {31'h0, pbo}, 0);
		wr(`OFS_CAPT, capt);
		wr(`OFS_CMPA, cmpa);
		wr(`OFS_FLAGS, 'hF);
		rd(`OFS_CMPA, d);
		chk("cmpa", d, c);
		wr(`OFS_CTRL, md | act << 4 | cs << 8 | 3 << 11);
		// In the PWM modes the first period runs on the old compare value
		for (k = 0; k < 2; k++) begin
			@(negedge aclk);
			hold(1, hi);
			hold(0, lo);
			hold(1, hi);
			hold(0, lo);
		end
		chk("high", hi, eh);
		chk("low", lo, el);
		chk("oe_on", {31'h0, pao}, 1);
		chk("oe_b_on", {31'h0, pbo}, 1);
		chk("pin_b_idle", {31'h0, pb}, 0);
		rd(`OFS_FLAGS, d);
		chk("flags", d & 'hB, (md == 12 || md == 14) << 3 | 2 | pw);
		$display("case mode %0d action %0d done", md, act);
	endtask

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a <= 'h18; a += 4) begin
			rd(a, d);
			chk("reset", d, 0);
		end
		wr('h1C, 1, 2'h2);
		rd('h1C, d, 2'h2);
		chk("unmapped", d, 0);
		wr(`OFS_COUNT, 'hFFFC);
		wr(`OFS_FLAGS, 'hF);
		wr(`OFS_CTRL, 1 << 8);
		repeat (20) @(posedge aclk);
		wr(`OFS_CTRL, 0);
		rd(`OFS_COUNT, d);
		chk("wrap", d > 0 && d < 'h40, 1);
		rd(`OFS_FLAGS, d);
		chk("ovf_set", d & 1, 1);
		wr(`OFS_FLAGS, 1);
		rd(`OFS_FLAGS, d);
		chk("ovf_clr", d & 1, 0);
		wr(`OFS_CTRL, 4);
		wr(`OFS_COUNT, 'h10);
		wr(`OFS_CMPA, 5);
		wr(`OFS_FLAGS, 'hF);
		wr(`OFS_CTRL, 4 | 1 << 8);
		repeat (20) @(posedge aclk);
		wr(`OFS_CTRL, 4);
		rd(`OFS_COUNT, d);
		chk("missed_top", d > 'h10 && d < 'h60, 1);
		rd(`OFS_FLAGS, d);
		chk("no_match", d & 3, 0);
		wr(`OFS_COUNT, 'hABCD, 2'h0, 4'h1);
		rd(`OFS_COUNT, d);
		chk("strobe", d, 'hCD);
		wr(`OFS_CTRL, 1 | 1 << 8);
		repeat (20) @(posedge aclk);
		rd(`OFS_COUNT, d);
		chk("unimpl_hold", d, 'hCD);
		$display("register tests done");
		run_case(4, 1, 1, 0, 9);
		run_case(4, 1, 2, 0, 3);
		run_case(4, 1, 3, 0, 1);
		run_case(4, 1, 4, 0, 0);
		run_case(4, 1, 5, 0, 0);
		run_case(12, 1, 1, 11, 2);
		run_case(15, 1, 1, 0, 6);
		run_case(5, 2, 1, 0, 'h1234);
		run_case(6, 3, 1, 0, 'h100);
		run_case(7, 2, 1, 0, 'h3FE);
		for (int k = 0; k < 2; k++) begin
			t = 3 + rnd() % 60;
			run_case(14, 2 + k, 1, t, rnd() % t);
			run_case(14, 2, 1, t, 0);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
